/* design/conversion_direction_control.sv */
// Function
// - reset comes up in automatic direction mode
// - auto: target above dc end charges
// - auto: target below dc end discharges
// - auto mode ignores pin and bus direction
// - battery mode takes effect after repower only
// - battery: way select 00h charge, 01h discharge
// - battery: charging uses charge volt and current settings
// - battery: discharging uses discharge volt and current settings
// - battery: pin high charges, low discharges
// - charge asked, battery above target: weak discharge
// - discharge asked, battery below target: weak charge
// - slow protections: fault 100 ms before shutdown
// - other protections: fault with shutdown together
// - fault low normally, high when not recyclable
// - dc good output low fine, high abnormal
// - output only while remote switch input low
`include "conv_dir_consts.svh"

module conversion_direction_control #(
   parameter int unsigned FAULT_LEAD_CYCLES = `FAULT_LEAD_CYCLES,
   parameter logic [15:0] RATED_CURRENT     = `RATED_CURRENT
) (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire conv_dir_pkg::host_cmd_t host_cmd,
   output conv_dir_pkg::host_rsp_t     host_rsp,
   input  wire logic                   repower,
   input  wire logic [15:0]            dc_voltage,
   input  wire logic [15:0]            trim_knob,
   input  wire logic                   charge_discharge_pin,
   input  wire logic                   remote_switch,
   input  wire conv_dir_pkg::protect_t protect_pins,
   output conv_dir_pkg::conv_dir_t     conv_dir,
   output logic [15:0]                 volt_target,
   output logic [15:0]                 curr_limit,
   output logic                        curr_reduced,
   output logic                        converter_run,
   output logic                        fault_output,
   output logic                        dc_good_output_n
);

   localparam int unsigned PIN_W = 7;
   localparam logic [15:0] REDUCED_CURR =
      16'((32'(RATED_CURRENT) * `REDUCED_PCT) / 100);

   // pin synchronisers
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_meta_reg;
   logic [PIN_W-1:0] pin_sync_reg;

   assign pin_raw = {charge_discharge_pin, remote_switch, protect_pins};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               pin_meta_reg[gi] <= 1'b0;
               pin_sync_reg[gi] <= 1'b0;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate

   conv_dir_pkg::protect_t prot_s;
   logic                   cd_pin_s;
   logic                   remote_s;

   assign prot_s   = pin_sync_reg[4:0];
   assign remote_s = pin_sync_reg[5];
   assign cd_pin_s = pin_sync_reg[6];

   // setting words
   logic [15:0] charge_volt_reg;
   logic [15:0] charge_curr_reg;
   logic [15:0] sys_setup_reg;
   logic [7:0]  way_select_reg;
   logic [15:0] dis_volt_reg;
   logic [15:0] dis_curr_reg;
   logic [15:0] two_way_reg;
   logic        battery_mode_reg;

   logic cmd_wr;
   logic cmd_rd;
   logic wr_charge_volt;
   logic wr_charge_curr;
   logic wr_sys_setup;
   logic wr_way_select;
   logic wr_dis_volt;
   logic wr_dis_curr;
   logic wr_two_way;

   assign cmd_wr         = host_cmd.valid & host_cmd.write;
   assign cmd_rd         = host_cmd.valid & ~host_cmd.write;
   assign wr_charge_volt = cmd_wr & (host_cmd.code == `CMD_CHARGE_VOLT);
   assign wr_charge_curr = cmd_wr & (host_cmd.code == `CMD_CHARGE_CURR);
   assign wr_sys_setup   = cmd_wr & (host_cmd.code == `CMD_SYS_SETUP);
   assign wr_way_select  = cmd_wr & (host_cmd.code == `CMD_WAY_SELECT);
   assign wr_dis_volt    = cmd_wr & (host_cmd.code == `CMD_DIS_VOLT);
   assign wr_dis_curr    = cmd_wr & (host_cmd.code == `CMD_DIS_CURR);
   assign wr_two_way     = cmd_wr & (host_cmd.code == `CMD_TWO_WAY);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         charge_volt_reg <= `RST_CHARGE_VOLT;
         charge_curr_reg <= `RST_CHARGE_CURR;
         sys_setup_reg   <= `RST_SYS_SETUP;
         way_select_reg  <= `RST_WAY_SELECT;
         dis_volt_reg    <= `RST_DIS_VOLT;
         dis_curr_reg    <= `RST_DIS_CURR;
         two_way_reg     <= `RST_TWO_WAY;
      end else begin
         if (wr_charge_volt) charge_volt_reg <= host_cmd.data;
         if (wr_charge_curr) charge_curr_reg <= host_cmd.data;
         if (wr_sys_setup)   sys_setup_reg   <= host_cmd.data;
         if (wr_way_select)  way_select_reg  <= host_cmd.data[7:0];
         if (wr_dis_volt)    dis_volt_reg    <= host_cmd.data;
         if (wr_dis_curr)    dis_curr_reg    <= host_cmd.data;
         if (wr_two_way)     two_way_reg     <= host_cmd.data;
      end
   end

   // mode is sampled only at repower so a live write cannot flip it mid-run
   logic battery_arm;

   assign battery_arm = (sys_setup_reg == `SYS_SETUP_BUS_MODE) &&
                        (two_way_reg == `TWO_WAY_BATTERY);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         battery_mode_reg <= 1'b0;
      end else if (repower) begin
         battery_mode_reg <= battery_arm;
      end
   end

   // direction request
   logic bus_ctrl;
   logic way_is_charge;
   logic way_is_dis;
   logic pin_req_charge;
   logic req_charge_reg;
   logic req_charge_next;

   assign bus_ctrl       = sys_setup_reg[`BUS_CTRL_BIT];
   assign way_is_charge  = (way_select_reg == `WAY_CHARGE);
   assign way_is_dis     = (way_select_reg == `WAY_DISCHARGE);
   assign pin_req_charge = cd_pin_s;

   // an undefined way value keeps the last request rather than guessing
   assign req_charge_next = !bus_ctrl     ? pin_req_charge :
                            way_is_charge ? 1'b1 :
                            way_is_dis    ? 1'b0 :
                            req_charge_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         req_charge_reg <= 1'b1;
      end else begin
         req_charge_reg <= req_charge_next;
      end
   end

   // automatic decision; equal voltages hold the present direction
   logic auto_charge;
   logic auto_dis;

   assign auto_charge = (trim_knob > dc_voltage);
   assign auto_dis    = (trim_knob < dc_voltage);

   // battery mode with forced reversal when the battery disagrees
   logic bat_over_charge;
   logic bat_under_dis;
   logic batt_charge;
   logic batt_reduced;

   assign bat_over_charge = (dc_voltage > charge_volt_reg);
   assign bat_under_dis   = (dc_voltage < dis_volt_reg);
   assign batt_reduced    = req_charge_reg ? bat_over_charge :
                                             bat_under_dis;
   assign batt_charge     = req_charge_reg ^ batt_reduced;

   // final direction, pin and bus unused in automatic mode
   logic dir_charge;
   logic dir_dis;

   assign dir_charge = battery_mode_reg ? batt_charge :
                       auto_charge ? 1'b1 :
                       auto_dis    ? 1'b0 :
                       (conv_dir == conv_dir_pkg::CONV_CHARGE);
   assign dir_dis    = !dir_charge;

   // setpoints that follow the direction
   logic        reduced_now;
   logic [15:0] volt_sel;
   logic [15:0] curr_sel;

   assign reduced_now = battery_mode_reg & batt_reduced;
   assign volt_sel    = !battery_mode_reg ? trim_knob :
                        dir_charge ? charge_volt_reg :
                                     dis_volt_reg;
   assign curr_sel    = reduced_now ? REDUCED_CURR :
                        dir_charge  ? charge_curr_reg :
                                      dis_curr_reg;

   // protection sequencing
   logic early_warn_prot;
   logic instant_prot;
   logic seq_fault;
   logic seq_shutdown;

   assign early_warn_prot = prot_s.overload | prot_s.short_circuit |
                            prot_s.over_temp;
   assign instant_prot    = prot_s.grid_loss | prot_s.other;

   fault_sequencer #(
      .LEAD_CYCLES     (FAULT_LEAD_CYCLES)
   ) u_fault_seq (
      .clock           (clock),
      .sys_rst         (sys_rst),
      .early_warn_prot (early_warn_prot),
      .instant_prot    (instant_prot),
      .fault_out       (seq_fault),
      .shutdown        (seq_shutdown)
   );

   // run enable and dc health
   logic        run_next;
   logic [31:0] dc_scaled;
   logic [31:0] good_floor;
   logic        dc_abnormal;

   assign run_next    = !remote_s && !seq_shutdown;
   assign dc_scaled   = 32'(dc_voltage) * 32'd100;
   assign good_floor  = 32'(volt_sel) * 32'(`DC_GOOD_PCT);
   assign dc_abnormal = !run_next || (dc_scaled < good_floor);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         conv_dir         <= conv_dir_pkg::CONV_IDLE;
         volt_target      <= 16'h0000;
         curr_limit       <= 16'h0000;
         curr_reduced     <= 1'b0;
         converter_run    <= 1'b0;
         fault_output     <= 1'b0;
         dc_good_output_n <= 1'b1;
      end else begin
         conv_dir         <= dir_charge ? conv_dir_pkg::CONV_CHARGE :
                                          conv_dir_pkg::CONV_DISCHARGE;
         volt_target      <= volt_sel;
         curr_limit       <= curr_sel;
         curr_reduced     <= reduced_now;
         converter_run    <= run_next;
         fault_output     <= seq_fault;
         dc_good_output_n <= dc_abnormal;
      end
   end

   // command read-back; unknown codes answer zero
   logic [15:0] status_word;
   logic [15:0] rd_data;

   always_comb begin
      status_word = 16'h0000;
      status_word[`STAT_BATTERY_POS]   = battery_mode_reg;
      status_word[`STAT_CHARGE_POS]    = (conv_dir == conv_dir_pkg::CONV_CHARGE);
      status_word[`STAT_DISCHARGE_POS] = (conv_dir == conv_dir_pkg::CONV_DISCHARGE);
      status_word[`STAT_REDUCED_POS]   = curr_reduced;
      status_word[`STAT_RUN_POS]       = converter_run;
      status_word[`STAT_FAULT_POS]     = fault_output;
   end

   assign rd_data =
      (host_cmd.code == `CMD_CHARGE_VOLT) ? charge_volt_reg :
      (host_cmd.code == `CMD_CHARGE_CURR) ? charge_curr_reg :
      (host_cmd.code == `CMD_SYS_STATUS)  ? status_word :
      (host_cmd.code == `CMD_SYS_SETUP)   ? sys_setup_reg :
      (host_cmd.code == `CMD_WAY_SELECT)  ? {8'h00, way_select_reg} :
      (host_cmd.code == `CMD_DIS_VOLT)    ? dis_volt_reg :
      (host_cmd.code == `CMD_DIS_CURR)    ? dis_curr_reg :
      (host_cmd.code == `CMD_TWO_WAY)     ? two_way_reg : 16'h0000;

   // writes never answer, matching the host link's habit
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         host_rsp <= '0;
      end else begin
         host_rsp.valid <= cmd_rd;
         host_rsp.data  <= cmd_rd ? rd_data : host_rsp.data;
      end
   end

   logic unused_ok;
   assign unused_ok = dir_dis;

endmodule

/* design/fault_sequencer.sv */
`include "conv_dir_consts.svh"

module fault_sequencer #(
   parameter int unsigned LEAD_CYCLES = `FAULT_LEAD_CYCLES
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic early_warn_prot,
   input  wire logic instant_prot,
   output logic      fault_out,
   output logic      shutdown
);

   logic [31:0] lead_cnt_reg;
   logic [31:0] lead_cnt_next;
   logic        lead_done;
   logic        any_prot;

   assign any_prot      = early_warn_prot | instant_prot;
   // full lead counted here; the shutdown flop adds no extra cycle against fault_out
   assign lead_done     = (lead_cnt_reg >= LEAD_CYCLES);
   assign lead_cnt_next = early_warn_prot && !lead_done ? lead_cnt_reg + 32'h1 :
                          early_warn_prot ? lead_cnt_reg : 32'h0;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lead_cnt_reg <= 32'h0;
         fault_out    <= 1'b0;
         shutdown     <= 1'b0;
      end else begin
         lead_cnt_reg <= lead_cnt_next;
         fault_out    <= any_prot;
         // early warning holds fault up for the whole lead before stopping
         shutdown     <= instant_prot | (early_warn_prot & lead_done);
      end
   end

endmodule

/* shared/conv_dir_consts.svh */
`ifndef CONV_DIR_CONSTS_SVH
`define CONV_DIR_CONSTS_SVH

// host command codes, one per setting word plus one for the read-only status word
`define CMD_CHARGE_VOLT    16'h0020
`define CMD_CHARGE_CURR    16'h0030
`define CMD_SYS_STATUS     16'h00C1
`define CMD_SYS_SETUP      16'h00C2
`define CMD_WAY_SELECT     16'h0100
`define CMD_DIS_VOLT       16'h0120
`define CMD_DIS_CURR       16'h0130
`define CMD_TWO_WAY        16'h0140

// setting values
`define SYS_SETUP_BUS_MODE 16'h0003
`define TWO_WAY_BATTERY    16'h0001
`define WAY_CHARGE         8'h00
`define WAY_DISCHARGE      8'h01
`define BUS_CTRL_BIT       0

// reset values
`define RST_CHARGE_VOLT    16'h1388
`define RST_CHARGE_CURR    16'h0BB8
`define RST_DIS_VOLT       16'h0FA0
`define RST_DIS_CURR       16'h0BB8
`define RST_SYS_SETUP      16'h0000
`define RST_WAY_SELECT     8'h00
`define RST_TWO_WAY        16'h0000

// status word fields
`define STAT_BATTERY_POS   0
`define STAT_CHARGE_POS    1
`define STAT_DISCHARGE_POS 2
`define STAT_REDUCED_POS   3
`define STAT_RUN_POS       4
`define STAT_FAULT_POS     5

// scaling and timing
`define RATED_CURRENT      16'h2710
`define REDUCED_PCT        5
`define DC_GOOD_PCT        80
`define FAULT_LEAD_MS      100
`define CLOCK_KHZ          125000
`define FAULT_LEAD_CYCLES  (`FAULT_LEAD_MS * `CLOCK_KHZ)

`endif

/* shared/conv_dir_pkg.sv */
package conv_dir_pkg;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_CHARGE,
      CONV_DISCHARGE
   } conv_dir_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] code;
      logic [15:0] data;
   } host_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } host_rsp_t;

   typedef struct packed {
      logic overload;
      logic short_circuit;
      logic over_temp;
      logic grid_loss;
      logic other;
   } protect_t;

endpackage

/* verification/conv_dir_monitor.sv */
module conv_dir_monitor #(
   parameter int unsigned FAULT_LEAD_CYCLES = 20,
   parameter logic [15:0] RATED_CURRENT     = 16'h2710
) (
   input wire logic                    clock,
   input wire logic                    sys_rst,
   input wire conv_dir_pkg::host_cmd_t host_cmd,
   input wire conv_dir_pkg::host_rsp_t host_rsp,
   input wire logic                    repower,
   input wire logic [15:0]             dc_voltage,
   input wire logic [15:0]             trim_knob,
   input wire logic                    charge_discharge_pin,
   input wire logic                    remote_switch,
   input wire conv_dir_pkg::protect_t  protect_pins,
   input wire conv_dir_pkg::conv_dir_t conv_dir,
   input wire logic [15:0]             volt_target,
   input wire logic [15:0]             curr_limit,
   input wire logic                    curr_reduced,
   input wire logic                    converter_run,
   input wire logic                    fault_output,
   input wire logic                    dc_good_output_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // eight run cycles are checked one by one, the rest of the lead is skipped
   localparam int LEAD_GAP = FAULT_LEAD_CYCLES - 9;
   localparam logic [15:0] REDUCED = 16'((32'(RATED_CURRENT) * 5) / 100);
   wire early_w   = protect_pins.overload | protect_pins.short_circuit | protect_pins.over_temp;
   wire instant_w = protect_pins.grid_loss | protect_pins.other;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // five samples cover the two sync stages plus the sequencer and output registers
   sequence calm_s; (!early_w && !instant_w)[*5]; endsequence
   sequence alarm_s; (early_w || instant_w)[*5]; endsequence
   sequence lead_s; ##1 converter_run[*8] ##LEAD_GAP converter_run ##1 !converter_run; endsequence
   read_answer_a: assert property (host_cmd.valid && !host_cmd.write |=> host_rsp.valid)
      else $error("read got no answer");
   dir_known_a: assert property (!$past(sys_rst) |-> conv_dir != conv_dir_pkg::CONV_IDLE)
      else $error("direction idle out of reset");
   reduced_limit_a: assert property (curr_reduced |-> curr_limit == REDUCED)
      else $error("reduced limit wrong");
   fault_low_a: assert property (calm_s |-> !fault_output)
      else $error("fault high without cause");
   fault_raise_a: assert property (alarm_s |-> fault_output)
      else $error("fault not raised");
   instant_shut_a: assert property (instant_w[*5] |-> !converter_run)
      else $error("instant fault kept running");
   early_lead_a: assert property ($rose(fault_output) && converter_run && !instant_w |-> lead_s)
      else $error("early fault lead wrong");
   remote_off_a: assert property (remote_switch[*5] |-> !converter_run)
      else $error("running while remote off");
   dc_idle_a: assert property (!converter_run[*2] |-> dc_good_output_n)
      else $error("dc good while stopped");
endmodule
bind conversion_direction_control conv_dir_monitor #(
   .FAULT_LEAD_CYCLES(FAULT_LEAD_CYCLES), .RATED_CURRENT(RATED_CURRENT)
) mon_u (
   .clock(clock), .sys_rst(sys_rst), .host_cmd(host_cmd), .host_rsp(host_rsp),
   .repower(repower), .dc_voltage(dc_voltage), .trim_knob(trim_knob),
   .charge_discharge_pin(charge_discharge_pin), .remote_switch(remote_switch),
   .protect_pins(protect_pins), .conv_dir(conv_dir), .volt_target(volt_target),
   .curr_limit(curr_limit), .curr_reduced(curr_reduced), .converter_run(converter_run),
   .fault_output(fault_output), .dc_good_output_n(dc_good_output_n)
);

/* verification/host_model.sv */
`include "conv_dir_consts.svh"
module host_model (
   input  wire logic                    clock,
   input  wire conv_dir_pkg::host_rsp_t host_rsp,
   output conv_dir_pkg::host_cmd_t      host_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial host_cmd = '0;
   task automatic issue(input logic wr_en, input logic [15:0] code, input logic [15:0] data);
      @(negedge clock);
      host_cmd = '{valid: 1'b1, write: wr_en, code: code, data: data};
      @(negedge clock);
      // released fields flip so stale values cannot pass
      host_cmd = '{valid: 1'b0, write: ~wr_en, code: ~code, data: ~data};
   endtask
   task automatic wr(input logic [15:0] code, input logic [15:0] data);
      issue(1'b1, code, data);
   endtask
   task automatic rd(input logic [15:0] code, output logic [15:0] data);
      issue(1'b0, code, 16'h0000);
      data = host_rsp.valid ? host_rsp.data : 16'hXXXX;
   endtask
   task automatic battery_setup;
      wr(`CMD_SYS_SETUP, `SYS_SETUP_BUS_MODE);
      wr(`CMD_TWO_WAY, `TWO_WAY_BATTERY);
   endtask
   task automatic pin_control;
      wr(`CMD_SYS_SETUP, `SYS_SETUP_BUS_MODE & ~16'h0001);
   endtask
endmodule

/* verification/test_conversion_direction_control.sv */
`include "conv_dir_consts.svh"
module test_conversion_direction_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned LEAD = 20;
   logic                    clock = 1'b0;
   logic                    sys_rst = 1'b1;
   logic                    repower = 1'b0;
   logic [15:0]             dc_voltage = 16'h1200;
   logic [15:0]             trim_knob = 16'h2000;
   logic                    cd_pin = 1'b0;
   logic                    remote_switch = 1'b0;
   conv_dir_pkg::protect_t  protect_pins = '0;
   conv_dir_pkg::host_cmd_t host_cmd;
   conv_dir_pkg::host_rsp_t host_rsp;
   conv_dir_pkg::conv_dir_t conv_dir;
   logic [15:0]             volt_target;
   logic [15:0]             curr_limit;
   logic                    curr_reduced;
   logic                    converter_run;
   logic                    fault_output;
   logic                    dc_good_output_n;
   int                      num_errors = 0;
   int                      samples_checked = 0;
   int                      cycles = 0;
   always #4 clock = ~clock;
   conversion_direction_control #(.FAULT_LEAD_CYCLES(LEAD)) dut_u (
      .clock(clock), .sys_rst(sys_rst), .host_cmd(host_cmd), .host_rsp(host_rsp),
      .repower(repower), .dc_voltage(dc_voltage), .trim_knob(trim_knob),
      .charge_discharge_pin(cd_pin), .remote_switch(remote_switch),
      .protect_pins(protect_pins), .conv_dir(conv_dir), .volt_target(volt_target),
      .curr_limit(curr_limit), .curr_reduced(curr_reduced), .converter_run(converter_run),
      .fault_output(fault_output), .dc_good_output_n(dc_good_output_n));
   host_model host_u (.clock(clock), .host_rsp(host_rsp), .host_cmd(host_cmd));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic rd_check(input logic [15:0] code, input logic [15:0] exp);
      logic [15:0] d;
      host_u.rd(code, d);
      check(d, exp);
   endtask
   task automatic dir_is(input conv_dir_pkg::conv_dir_t exp);
      check({14'h0, conv_dir}, {14'h0, exp});
   endtask
   task automatic t_regs;
      logic [15:0] codes [7] = '{`CMD_CHARGE_VOLT, `CMD_CHARGE_CURR, `CMD_DIS_VOLT,
                                 `CMD_DIS_CURR, `CMD_SYS_SETUP, `CMD_WAY_SELECT, `CMD_TWO_WAY};
      logic [15:0] rstv [7] = '{`RST_CHARGE_VOLT, `RST_CHARGE_CURR, `RST_DIS_VOLT,
                                `RST_DIS_CURR, `RST_SYS_SETUP, 16'(`RST_WAY_SELECT), `RST_TWO_WAY};
      logic [15:0] vals [4] = '{16'h1400, 16'h0300, 16'h1000, 16'h0280};
      for (int i = 0; i < 7; i++)
         rd_check(codes[i], rstv[i]);
      for (int i = 0; i < 4; i++) begin
         host_u.wr(codes[i], vals[i]);
         rd_check(codes[i], vals[i]);
      end
      host_u.wr(`CMD_WAY_SELECT, 16'hAB01);
      rd_check(`CMD_WAY_SELECT, 16'h0001);
      host_u.wr(16'h0055, 16'h1234);
      rd_check(16'h0055, 16'h0000);
      $display("test regs done");
   endtask
   task automatic t_auto;
      tick(4);
      dir_is(conv_dir_pkg::CONV_CHARGE);
      rd_check(`CMD_SYS_STATUS, 16'h0012);
      trim_knob = 16'h1000;
      tick(4);
      dir_is(conv_dir_pkg::CONV_DISCHARGE);
      cd_pin = 1'b1;
      tick(5);
      dir_is(conv_dir_pkg::CONV_DISCHARGE);
      $display("test auto done");
   endtask
   task automatic t_battery;
      host_u.battery_setup();
      host_u.wr(`CMD_WAY_SELECT, 16'h0000);
      tick(3);
      dir_is(conv_dir_pkg::CONV_DISCHARGE);
      repower = 1'b1;
      tick(1);
      repower = 1'b0;
      tick(3);
      dir_is(conv_dir_pkg::CONV_CHARGE);
      check(volt_target, 16'h1400);
      check(curr_limit, 16'h0300);
      check({15'h0, dc_good_output_n}, 16'h0000);
      host_u.wr(`CMD_WAY_SELECT, 16'h0001);
      tick(3);
      dir_is(conv_dir_pkg::CONV_DISCHARGE);
      check(volt_target, 16'h1000);
      check(curr_limit, 16'h0280);
      dc_voltage = 16'h0F00;
      tick(3);
      dir_is(conv_dir_pkg::CONV_CHARGE);
      check({curr_reduced, curr_limit}, {1'b1, 16'h01F4});
      host_u.wr(`CMD_WAY_SELECT, 16'h0000);
      tick(3);
      check({15'h0, dc_good_output_n}, 16'h0001);
      dc_voltage = 16'h1500;
      tick(3);
      dir_is(conv_dir_pkg::CONV_DISCHARGE);
      check({curr_reduced, curr_limit}, {1'b1, 16'h01F4});
      host_u.pin_control();
      dc_voltage = 16'h1200;
      cd_pin = 1'b0;
      tick(5);
      dir_is(conv_dir_pkg::CONV_DISCHARGE);
      cd_pin = 1'b1;
      tick(5);
      dir_is(conv_dir_pkg::CONV_CHARGE);
      $display("test battery done");
   endtask
   task automatic t_fault;
      int k;
      check({fault_output, converter_run}, 2'b01);
      protect_pins.overload = 1'b1;
      for (k = 0; k < 8 && fault_output !== 1'b1; k++)
         tick(1);
      check({fault_output, converter_run}, 2'b11);
      for (k = 0; k < 60 && converter_run !== 1'b0; k++)
         tick(1);
      check(16'(k), 16'(LEAD));
      protect_pins = '0;
      tick(5);
      check({fault_output, converter_run}, 2'b01);
      protect_pins.grid_loss = 1'b1;
      for (k = 0; k < 8 && fault_output !== 1'b1; k++)
         tick(1);
      check({fault_output, converter_run}, 2'b10);
      protect_pins = '0;
      tick(5);
      $display("test fault done");
   endtask
   task automatic t_remote;
      remote_switch = 1'b1;
      tick(5);
      check({converter_run, dc_good_output_n}, 2'b01);
      remote_switch = 1'b0;
      tick(5);
      check({15'h0, converter_run}, 16'h0001);
      $display("test remote done");
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      tick(6);
      sys_rst = 1'b0;
      t_regs();
      t_auto();
      t_battery();
      t_fault();
      t_remote();
      conclude();
   end
endmodule
